// [lut_bus_pkg.sv]
/*
 package of constants for the lookup-table bus access control block.
 assumes: bus strobes are active-high levels asynchronous to core_clk.
*/
// Functional notes
// RULE_01: data drivers receive unless a table read
// RULE_02: counter loads from data or increments
// RULE_03: decode five selects from bus address
// RULE_04: address bit 0 picks low/high byte
// RULE_05: source flags at byte 800A/800B
// RULE_06: destination flags at byte 800C/800D
// RULE_07: synced reset clears flags and read state
// RULE_08: counter addresses table during data transfers
// RULE_09: pixel data addresses otherwise; blank when selected
// RULE_10: grant ignored unless a flag set; resynced
// RULE_11: read strobe with data select drives bus
// RULE_12: read trailing edge with high select increments
// RULE_13: write leading edge high select writes table
// RULE_14: processor high write also increments counter
// RULE_15: write edge with flag select loads flags
// RULE_16: write edge with counter select loads counter
// RULE_17: into-table dma: destination flag, address, grant
// RULE_18: dma write strobe resynced, edge writes table
// RULE_19: dma write term drives acknowledge to sender
// RULE_20: write trailing edge increments; repeat while grant
// RULE_21: out-of-table dma: source flag, address, grant
// RULE_22: pending read sets read state, drives write
// RULE_23: synced acknowledge increments, withdraws pending read
// RULE_24: state drops on half-clock edge; wait release
// RULE_25: all async inputs synced before edge detection
package lut_bus_pkg;
   localparam int BUS_W = 16;
   localparam int CNT_W = 10;
   localparam int TBL_W = 12;
   localparam int SYNC_N = 6;
   localparam logic [15:0] CNT_BASE = 16'h8060;
   localparam logic [15:0] DATA_BASE = 16'h8062;
   localparam logic [15:0] SRC_BASE = 16'h800a;
   localparam logic [15:0] DST_BASE = 16'h800c;
   localparam int FLAG_LSB = 4;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
   // sync channel indices
   localparam int CH_RD = 0;
   localparam int CH_WR = 1;
   localparam int CH_GNT = 2;
   localparam int CH_ACK = 3;
   localparam int CH_HALF = 4;
   localparam int CH_RST = 5;
   // register map
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam int CTRL_EN = 0;
   localparam int CTRL_IDX = 1;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [3:0] {
      RD_IDLE = 4'h1,
      RD_DRIVE = 4'h2,
      RD_ACKED = 4'h4,
      RD_RELEASE = 4'h8
   } rd_state_t;
endpackage : lut_bus_pkg

// [sync_if.sv]
/*
 carrier for synchronised levels and their edge pulses.
 assumes: one core_clk domain.
*/
`timescale 1ns/1ps
interface sync_if;
   logic [lut_bus_pkg::SYNC_N-1:0] level;
   logic [lut_bus_pkg::SYNC_N-1:0] rise;
   logic [lut_bus_pkg::SYNC_N-1:0] fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : sync_if

// [strobe_sync.sv]
/*
 two-flop synchronisers with edge detection, one per asynchronous input.
 assumes: core_clk, synchronous active-low resetn.
*/
`timescale 1ns/1ps
module strobe_sync (
   input  wire logic                           core_clk,
   input  wire logic                           resetn,
   input  wire logic [lut_bus_pkg::SYNC_N-1:0] rawIn,
   sync_if.src                                 sy
);
   genvar i;
   generate
      for (i = 0; i < lut_bus_pkg::SYNC_N; i++) begin : g_ch
         logic meta_q;
         logic stage_q;
         logic prev_q;
         // edges come from the second and third flop, never the first
         always_ff @(posedge core_clk) begin
            if (!resetn) begin
               meta_q <= 1'b0;
               stage_q <= 1'b0;
               prev_q <= 1'b0;
            end else begin
               meta_q <= rawIn[i];
               stage_q <= meta_q;
               prev_q <= stage_q;
            end
         end
         assign sy.level[i] = stage_q; // RULE_25
         assign sy.rise[i] = stage_q & ~prev_q;
         assign sy.fall[i] = ~stage_q & prev_q;
      end
   endgenerate
endmodule : strobe_sync

// [lut_bus_access_control.sv]
/*
 bus-side control of a colour lookup table: data drivers, address counter,
 address decode, dma flags, processor and dma table transfers, axi4-lite
 control/status.
 assumes: table ram and pixel path outside; bus strobes active-high levels.
*/
`timescale 1ns/1ps
module lut_bus_access_control (
   input  wire logic                          core_clk,
   input  wire logic                          resetn,
   input  wire logic                          systemResetIn,
   input  wire logic                          halfClk,
   input  wire logic [15:0]                   busAddr,
   input  wire logic [lut_bus_pkg::BUS_W-1:0] busDataIn,
   output logic [lut_bus_pkg::BUS_W-1:0]      busDataOut,
   output logic                               busDataOeN,
   input  wire logic                          busReadStrobe,
   input  wire logic                          busWriteIn,
   output logic                               busWriteOut,
   output logic                               busWriteOeN,
   input  wire logic                          busDmaGrant,
   input  wire logic                          busAckIn,
   output logic                               busAckOut,
   output logic                               busAckOeN,
   input  wire logic [lut_bus_pkg::CNT_W-1:0] pixelData,
   input  wire logic [lut_bus_pkg::TBL_W-1:0] tableRdData,
   output logic [lut_bus_pkg::CNT_W-1:0]      tableAddr,
   output logic [lut_bus_pkg::TBL_W-1:0]      tableWrData,
   output logic                               tableRamWritePulse,
   output logic                               counterAddrSelect,
   output logic                               videoBlank,
   input  wire logic [31:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [31:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);
   sync_if sy ();
   strobe_sync u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .rawIn    ({systemResetIn, halfClk, busAckIn, busDmaGrant, busWriteIn, busReadStrobe}),
      .sy       (sy)
   );

   logic                    syncReset_q;
   logic [2:0]              ctrl_q;
   logic [lut_bus_pkg::CNT_W-1:0] counter_q;
   logic                    sourceFlag_q;
   logic                    destinationFlag_q;
   lut_bus_pkg::rd_state_t  rdState_q;
   logic                    readDmaStateB_q;
   logic                    selLoadAddr, selDataLow, selDataHigh, selSrcFlags, selDstFlags;
   logic                    grantSynced, writeSynced, pioOk, writeLeadingEdge;
   logic                    readLowByte, readHighByte, readDmaState, readTrailingEdge;
   logic                    addrCounterLoadEn, addrCounterIncr, pioTableWrite;
   logic                    srcFlagClock, dstFlagClock, dmaFlagActive, pioDataAccess;
   logic                    destinationDma, sourceDma, dmaWriteTerm, dmaTableWrite;
   logic                    dmaWriteIncr, dmaReadIncr, dmaReadPending, ackSynced;
   logic [1:0]              tableIdx;
   logic                    flagBit;
   logic                    localReset;
   logic                    enabled;

   // enable and table index come from the control register
   assign enabled = ctrl_q[lut_bus_pkg::CTRL_EN];
   assign tableIdx = ctrl_q[lut_bus_pkg::CTRL_IDX+:2];
   assign flagBit = busDataIn[lut_bus_pkg::FLAG_LSB + int'(tableIdx)];
   assign localReset = !resetn || syncReset_q;

   // byte address decode; bit 0 chooses the byte lane
   assign selLoadAddr = busAddr[15:1] == lut_bus_pkg::CNT_BASE[15:1]; // RULE_03
   assign selDataLow = (busAddr[15:1] == lut_bus_pkg::DATA_BASE[15:1]) && !busAddr[0]; // RULE_04
   assign selDataHigh = (busAddr[15:1] == lut_bus_pkg::DATA_BASE[15:1]) && busAddr[0]; // RULE_04
   assign selSrcFlags = busAddr[15:1] == lut_bus_pkg::SRC_BASE[15:1]; // RULE_05
   assign selDstFlags = busAddr[15:1] == lut_bus_pkg::DST_BASE[15:1]; // RULE_06

   assign grantSynced = sy.level[lut_bus_pkg::CH_GNT]; // RULE_10
   assign writeSynced = sy.level[lut_bus_pkg::CH_WR];
   assign ackSynced = sy.level[lut_bus_pkg::CH_ACK]; // RULE_23
   // processor cycles are ignored while a dma grant is honoured
   assign pioOk = enabled && !dmaFlagActive;
   assign writeLeadingEdge = sy.rise[lut_bus_pkg::CH_WR] && pioOk;
   assign readTrailingEdge = sy.fall[lut_bus_pkg::CH_RD] && pioOk; // RULE_12

   assign readLowByte = sy.level[lut_bus_pkg::CH_RD] && selDataLow && pioOk; // RULE_11
   assign readHighByte = sy.level[lut_bus_pkg::CH_RD] && selDataHigh && pioOk; // RULE_11
   assign readDmaState = (rdState_q == lut_bus_pkg::RD_DRIVE) || (rdState_q == lut_bus_pkg::RD_ACKED);

   assign addrCounterLoadEn = writeLeadingEdge && selLoadAddr; // RULE_16
   assign pioTableWrite = writeLeadingEdge && selDataHigh; // RULE_13
   assign srcFlagClock = writeLeadingEdge && selSrcFlags; // RULE_15
   assign dstFlagClock = writeLeadingEdge && selDstFlags; // RULE_15

   assign dmaFlagActive = enabled && grantSynced && (sourceFlag_q || destinationFlag_q); // RULE_10
   assign pioDataAccess = selDataLow || selDataHigh;
   assign destinationDma = dmaFlagActive && destinationFlag_q; // RULE_17
   assign sourceDma = dmaFlagActive && sourceFlag_q && !destinationFlag_q; // RULE_21
   assign dmaWriteTerm = writeSynced && destinationDma; // RULE_18
   assign dmaTableWrite = sy.rise[lut_bus_pkg::CH_WR] && destinationDma; // RULE_18
   assign dmaWriteIncr = sy.fall[lut_bus_pkg::CH_WR] && destinationDma; // RULE_20
   assign dmaReadPending = sourceDma && !ackSynced && (rdState_q == lut_bus_pkg::RD_IDLE);
   assign dmaReadIncr = sy.rise[lut_bus_pkg::CH_ACK] && readDmaStateB_q && (rdState_q == lut_bus_pkg::RD_DRIVE); // RULE_23

   // every source of an increment funnels into one pulse
   assign addrCounterIncr = (readTrailingEdge && selDataHigh) || pioTableWrite // RULE_14
                            || dmaWriteIncr || dmaReadIncr; // RULE_12

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         syncReset_q <= 1'b0;
      end else begin
         syncReset_q <= sy.level[lut_bus_pkg::CH_RST]; // RULE_07
      end
   end

   // a load wins over an increment landing in the same cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         counter_q <= '0;
      end else if (addrCounterLoadEn) begin
         counter_q <= busDataIn[lut_bus_pkg::CNT_W-1:0]; // RULE_02
      end else if (addrCounterIncr) begin
         counter_q <= counter_q + lut_bus_pkg::CNT_ONE; // RULE_02
      end
   end

   always_ff @(posedge core_clk) begin
      if (localReset) begin
         sourceFlag_q <= 1'b0; // RULE_07
         destinationFlag_q <= 1'b0;
      end else begin
         if (srcFlagClock) begin
            sourceFlag_q <= flagBit; // RULE_15
         end
         if (dstFlagClock) begin
            destinationFlag_q <= flagBit; // RULE_15
         end
      end
   end

   // dma read handshake: drive, see acknowledge, drop on half clock, wait release
   always_ff @(posedge core_clk) begin
      if (localReset) begin
         rdState_q <= lut_bus_pkg::RD_IDLE; // RULE_07
      end else begin
         case (rdState_q)
            lut_bus_pkg::RD_IDLE: begin
               if (dmaReadPending) begin
                  rdState_q <= lut_bus_pkg::RD_DRIVE; // RULE_22
               end
            end
            lut_bus_pkg::RD_DRIVE: begin
               if (dmaReadIncr) begin
                  rdState_q <= lut_bus_pkg::RD_ACKED; // RULE_23
               end else if (!sourceDma) begin
                  rdState_q <= lut_bus_pkg::RD_IDLE;
               end
            end
            lut_bus_pkg::RD_ACKED: begin
               if (sy.rise[lut_bus_pkg::CH_HALF] || sy.fall[lut_bus_pkg::CH_HALF]) begin
                  rdState_q <= lut_bus_pkg::RD_RELEASE; // RULE_24
               end
            end
            lut_bus_pkg::RD_RELEASE: begin
               if (!ackSynced) begin
                  rdState_q <= lut_bus_pkg::RD_IDLE; // RULE_24
               end
            end
            default: rdState_q <= lut_bus_pkg::RD_IDLE;
         endcase
      end
   end

   // delayed copy keeps the write strobe behind valid data
   always_ff @(posedge core_clk) begin
      if (localReset) begin
         readDmaStateB_q <= 1'b0;
      end else begin
         readDmaStateB_q <= readDmaState; // RULE_22
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         busDataOut <= '0;
         busDataOeN <= 1'b1;
      end else begin
         busDataOut <= {{(lut_bus_pkg::BUS_W-lut_bus_pkg::TBL_W){1'b0}}, tableRdData}; // RULE_11
         busDataOeN <= !(readLowByte || readHighByte || readDmaState); // RULE_01
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         busWriteOut <= 1'b0;
         busWriteOeN <= 1'b1;
         busAckOut <= 1'b0;
         busAckOeN <= 1'b1;
      end else begin
         busWriteOut <= readDmaStateB_q;
         busWriteOeN <= !readDmaStateB_q; // RULE_22
         busAckOut <= dmaWriteTerm;
         busAckOeN <= !dmaWriteTerm; // RULE_19
      end
   end

   // table address switches before the data moves; video is blanked meanwhile
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         counterAddrSelect <= 1'b0;
         videoBlank <= 1'b0;
         tableAddr <= '0;
         tableWrData <= '0;
         tableRamWritePulse <= 1'b0;
      end else begin
         counterAddrSelect <= dmaFlagActive || (pioDataAccess && enabled); // RULE_08
         videoBlank <= dmaFlagActive || (pioDataAccess && enabled); // RULE_09
         tableAddr <= (dmaFlagActive || (pioDataAccess && enabled)) ? counter_q : pixelData; // RULE_09
         tableWrData <= busDataIn[lut_bus_pkg::TBL_W-1:0];
         tableRamWritePulse <= pioTableWrite || dmaTableWrite; // RULE_13
      end
   end

   // axi4-lite slave; address and data may arrive in either order
   logic       awHeld_q, wHeld_q;
   logic [3:0] awOfs_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic       wrGo;
   assign wrGo = awHeld_q && wHeld_q && !s_axi_bvalid;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awOfs_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lut_bus_pkg::RESP_OK;
         ctrl_q <= lut_bus_pkg::CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awOfs_q <= s_axi_awaddr[3:0];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrGo) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awOfs_q == lut_bus_pkg::CTRL_OFS) begin
               s_axi_bresp <= lut_bus_pkg::RESP_OK;
               if (wStrb_q[0]) begin
                  ctrl_q <= wData_q[2:0];
               end
            end else if (awOfs_q == lut_bus_pkg::STAT_OFS) begin
               s_axi_bresp <= lut_bus_pkg::RESP_OK;
            end else begin
               s_axi_bresp <= lut_bus_pkg::RESP_ERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= lut_bus_pkg::RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= lut_bus_pkg::RESP_OK;
         if (s_axi_araddr[3:0] == lut_bus_pkg::CTRL_OFS) begin
            s_axi_rdata <= {29'h0, ctrl_q};
         end else if (s_axi_araddr[3:0] == lut_bus_pkg::STAT_OFS) begin
            s_axi_rdata <= {12'h0, rdState_q, grantSynced, readDmaState, destinationFlag_q, sourceFlag_q,
                            2'h0, counter_q};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= lut_bus_pkg::RESP_ERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   drive_dir_a: assert property (!busDataOeN |-> $past(readLowByte || readHighByte || readDmaState)) // RULE_01
      else $error("data drivers on without a table read");
   cnt_load_a: assert property (addrCounterLoadEn |=> counter_q == $past(busDataIn[9:0])) // RULE_16
      else $error("counter did not load");
   cnt_incr_a: assert property (addrCounterIncr && !addrCounterLoadEn |=> counter_q == $past(counter_q) + 10'h001) // RULE_14
      else $error("counter did not increment");
   flag_load_a: assert property (srcFlagClock && !syncReset_q |=> sourceFlag_q == $past(flagBit)) // RULE_15
      else $error("source flag not loaded");
   reset_clear_a: assert property (syncReset_q |=> !sourceFlag_q && !destinationFlag_q && !readDmaState) // RULE_07
      else $error("synced reset did not clear state");
   sel_addr_a: assert property (dmaFlagActive |=> counterAddrSelect && videoBlank && tableAddr == $past(counter_q)) // RULE_08
      else $error("counter not selected during transfer");
   grant_ignore_a: assert property (!sourceFlag_q && !destinationFlag_q |=> busAckOeN) // RULE_10
      else $error("grant honoured without a flag");
   pio_write_a: assert property (pioTableWrite |=> tableRamWritePulse ##1 !tableRamWritePulse) // RULE_13
      else $error("table write pulse missing");
   dma_ack_a: assert property (!busAckOeN |-> $past(dmaWriteTerm)) // RULE_19
      else $error("acknowledge without dma write term");
   write_drive_a: assert property (readDmaState |=> ##1 (!busWriteOeN || !readDmaStateB_q)) // RULE_22
      else $error("dma write strobe not driven");
   ack_step_a: assert property (dmaReadIncr |=> rdState_q == lut_bus_pkg::RD_ACKED && !dmaReadPending) // RULE_23
      else $error("acknowledge did not advance read");
   half_drop_a: assert property (rdState_q == lut_bus_pkg::RD_ACKED && sy.rise[lut_bus_pkg::CH_HALF] |=> !readDmaState) // RULE_24
      else $error("read state did not drop on half clock");

   pio_write_c: cover property (pioTableWrite ##1 tableRamWritePulse);
   dma_write_c: cover property (dmaTableWrite ##[1:20] dmaWriteIncr);
   dma_read_c: cover property (dmaReadIncr ##[1:40] rdState_q == lut_bus_pkg::RD_IDLE);
endmodule : lut_bus_access_control

// [lut_bus_partner.sv]
/*
 far-side bus board: pio master, dma sender and dma receiver.
 assumes one core_clk domain and active-high strobes.
*/
`timescale 1ns/1ps
module lut_bus_partner (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [15:0] busDataOut,
   input  wire logic        busDataOeN,
   input  wire logic        busWriteOut,
   input  wire logic        busWriteOeN,
   input  wire logic        busAckOut,
   input  wire logic        busAckOeN,
   output logic      [15:0] busAddr,
   output logic      [15:0] busDataIn,
   output logic             busReadStrobe,
   output logic             busWriteIn,
   output logic             busAckIn
);
   logic        ackDly;
   logic        rxBad;
   logic [15:0] rxFirst;
   int          rxCnt;
   initial {busAddr, busDataIn, busReadStrobe, busWriteIn} = '0;
   // ack held until the strobe is withdrawn, so the next word waits for release
   always @(posedge core_clk) begin
      if (!resetn) begin
         ackDly <= 1'b0;
         busAckIn <= 1'b0;
         rxCnt <= 0;
         rxBad <= 1'b0;
      end else begin
         ackDly <= busWriteOut && !busWriteOeN;
         busAckIn <= ackDly;
         if (ackDly && !busAckIn) begin
            rxCnt <= rxCnt + 1;
            if (rxCnt == 0) rxFirst <= busDataOut;
            if (busDataOeN !== 1'b0) rxBad <= 1'b1;
         end
      end
   end
   task automatic busWr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      busAddr <= a;
      busDataIn <= d;
      busWriteIn <= 1'b1;
      repeat (6) @(posedge core_clk);
      busWriteIn <= 1'b0;
      repeat (6) @(posedge core_clk);
      busDataIn <= ~d;
   endtask : busWr
   task automatic busRd(input logic [15:0] a, output logic [15:0] d, output logic oe);
      @(posedge core_clk);
      busAddr <= a;
      busReadStrobe <= 1'b1;
      repeat (6) @(posedge core_clk);
      d = busDataOut;
      oe = busDataOeN;
      busReadStrobe <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask : busRd
   // sender holds its strobe until the table side acknowledges or 20 cycles pass
   task automatic dmaSend(input logic [15:0] d, output logic ok);
      @(posedge core_clk);
      ok = 1'b0;
      busDataIn <= d;
      busWriteIn <= 1'b1;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge core_clk);
         ok = busAckOut && !busAckOeN;
      end
      busWriteIn <= 1'b0;
      repeat (6) @(posedge core_clk);
      busDataIn <= ~d;
   endtask : dmaSend
endmodule : lut_bus_partner

// [test_lut_bus_access_control.sv]
/*
 self-checking bench: axi4-lite control, pio and dma table traffic.
 assumes the partner model drives the bus side.
*/
`timescale 1ns/1ps
module test_lut_bus_access_control;
   logic core_clk = 0, resetn = 0, systemResetIn = 0, halfClk = 0, busDmaGrant = 0;
   logic [15:0] busAddr, busDataIn, busDataOut, rdat;
   logic busDataOeN, busReadStrobe, busWriteIn, busWriteOut, busWriteOeN, busAckIn, busAckOut, busAckOeN;
   logic [9:0] pixelData = 0, tableAddr, pAddr;
   logic [11:0] tableRdData = 0, tableWrData, pData;
   logic tableRamWritePulse, counterAddrSelect, videoBlank, oe, ok;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, st;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_mismatch = 0, tests_run = 0, nPulse = 0;
   lut_bus_access_control i_dut (.*);
   lut_bus_partner i_peer (.*);
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      halfClk <= ~halfClk;
      pixelData <= pixelData + 10'h001;
      tableRdData <= {2'h0, tableAddr} ^ 12'h5a5;
      if (tableRamWritePulse === 1'b1) begin
         nPulse++;
         pAddr <= tableAddr;
         pData <= tableWrData;
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge core_clk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axiWr
   task automatic axiRd(input logic [31:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge core_clk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {st, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : axiRd
   task automatic tally_and_finish;
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // the whole sequence needs well under half of this span
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      axiWr(32'h0, 32'h1);
      chk("ctrl resp", rr, 2'h0);
      axiRd(32'h8);
      chk("unmapped resp", rr, 2'h2);
      i_peer.busWr(16'h8060, 16'h0005);
      axiRd(32'h4);
      chk("counter load", st[9:0], 10'h005);
      i_peer.busWr(16'h8063, 16'h0abc);
      chk("pio pulses", nPulse, 1);
      chk("pio addr", pAddr, 10'h005);
      chk("pio data", pData, 12'habc);
      axiRd(32'h4);
      chk("incr on write", st[9:0], 10'h006);
      i_peer.busWr(16'h8062, 16'h0123);
      chk("low write", nPulse, 1);
      i_peer.busRd(16'h8063, rdat, oe);
      chk("read drive", oe, 1'b0);
      chk("read data", rdat, {4'h0, 12'h006 ^ 12'h5a5});
      i_peer.busRd(16'h8062, rdat, oe);
      chk("low read data", rdat, {4'h0, 12'h007 ^ 12'h5a5});
      axiRd(32'h4);
      chk("incr on read", st[9:0], 10'h007);
      chk("idle receive", busDataOeN, 1'b1);
      busDmaGrant <= 1'b1;
      i_peer.busWr(16'h8060, 16'h0003);
      chk("grant no flag", counterAddrSelect, 1'b0);
      chk("pixel addr", tableAddr, 10'(pixelData - 10'h001));
      axiRd(32'h4);
      chk("grant ignored", {st[15], st[9:0]}, {1'b1, 10'h003});
      busDmaGrant <= 1'b0;
      i_peer.busWr(16'h800b, 16'h0010);
      axiRd(32'h4);
      chk("source flag", st[13:12], 2'h1);
      i_peer.busWr(16'h800d, 16'h0010);
      axiRd(32'h4);
      chk("dest flag", st[13:12], 2'h3);
      systemResetIn <= 1'b1;
      repeat (8) @(posedge core_clk);
      systemResetIn <= 1'b0;
      axiRd(32'h4);
      chk("board clear", st[14:12], 3'h0);
      i_peer.busWr(16'h800c, 16'h0010);
      i_peer.busWr(16'h8060, 16'h000a);
      busDmaGrant <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk("counter select", counterAddrSelect, 1'b1);
      chk("blank", videoBlank, 1'b1);
      i_peer.dmaSend(16'h0111, ok);
      chk("dma ack", ok, 1'b1);
      i_peer.dmaSend(16'h0222, ok);
      chk("dma pulses", nPulse, 3);
      chk("dma data", pData, 12'h222);
      chk("dma addr", pAddr, 10'h00b);
      busDmaGrant <= 1'b0;
      axiRd(32'h4);
      chk("dma in count", st[9:0], 10'h00c);
      i_peer.busWr(16'h800c, 16'h0000);
      i_peer.busWr(16'h800a, 16'h0010);
      i_peer.busWr(16'h8060, 16'h0014);
      busDmaGrant <= 1'b1;
      for (int i = 0; i < 400 && i_peer.rxCnt < 3; i++) @(posedge core_clk);
      busDmaGrant <= 1'b0;
      repeat (30) @(posedge core_clk);
      chk("words out", i_peer.rxCnt >= 3, 1);
      chk("first word", i_peer.rxFirst, {4'h0, 12'h014 ^ 12'h5a5});
      chk("driven during", i_peer.rxBad, 1'b0);
      chk("strobe off", busWriteOeN, 1'b1);
      axiRd(32'h4);
      chk("dma out count", st[9:0], 10'h014 + i_peer.rxCnt[9:0]);
      tally_and_finish;
   end
endmodule : test_lut_bus_access_control
